// [hw/csx_regs.svh]
`ifndef CSX_REGS_SVH
`define CSX_REGS_SVH
`define CSX_OFS_CTRL 8'h00
`define CSX_OFS_POL 8'h04
`define CSX_OFS_FLO 8'h08
`define CSX_OFS_FHI 8'h0c
`define CSX_OFS_DLY 8'h10
`define CSX_OFS_STAT 8'h14
`define CSX_CTRL_MODE 0
`define CSX_CTRL_GUARD 1
`define CSX_CTRL_KRST 2
`define CSX_RST_CTRL 32'h0000_0000
`define CSX_RST_POL 32'h0000_0000
`define CSX_RST_FUNC 32'h0000_0000
`define CSX_RST_DLY 32'h0000_0000
`define CSX_FN_COAST 8'h0b
`define CSX_FN_TRIP 8'h0c
`define CSX_ERR_EXT 8'h0c
`define CSX_ERR_NONE 8'h00
`define CSX_TICK_US 1000
`define CSX_CLK_NS 5
`define CSX_TICK_CYC (`CSX_TICK_US * 1000 / `CSX_CLK_NS)
`endif

// [hw/csx_pkg.sv]
package csx_pkg;
   typedef enum logic [2:0] {
      ST_STOP, ST_RUN, ST_COAST, ST_WAIT, ST_TRIP, ST_CLR, ST_HOLD
   } csx_state_t;
   typedef logic [1:0] csx_resp_t;
   localparam csx_resp_t CSX_OKAY = 2'h0;
   localparam csx_resp_t CSX_SLVERR = 2'h2;

   // Any active terminal whose assigned function matches code
   function automatic logic csx_fn_any(input logic [63:0] fa, input logic [7:0] lv,
                                       input logic [7:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (lv[i] && fa[8*i +: 8] == code) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction
endpackage

// [hw/csx_ifs.sv]
`timescale 1ns/1ps
interface csx_cfg_if;
   logic mode;
   logic guard;
   logic krst;
   logic [7:0] pol;
   logic [63:0] fa;
   logic [15:0] dly;
   logic [31:0] stat;
   modport regs(output mode, guard, krst, pol, fa, dly, input stat);
   modport core(input mode, guard, krst, pol, fa, dly, output stat);
endinterface

interface csx_term_if;
   logic coast;
   logic trip_lvl;
   logic trip_rise;
   modport src(output coast, trip_lvl, trip_rise);
   modport snk(input coast, trip_lvl, trip_rise);
endinterface

// [hw/csx_insync.sv]
`timescale 1ns/1ps
`include "csx_regs.svh"
module csx_insync (
   input wire logic clk, // Clock
   input wire logic rst_n, // Async reset, low
   input wire logic [7:0] term, // Raw terminals
   input wire logic [7:0] pol, // Per-terminal inversion
   input wire logic [63:0] fa, // Function code per terminal
   csx_term_if.src tio // Conditioned functions
);
   import csx_pkg::*;
   logic [7:0] s1_q, s1_d, s2_q, s2_d, lv;
   logic coast_q, coast_d, trip_q, trip_d, rise_q, rise_d;

   always_comb begin
      s1_d = term;
      s2_d = s1_q;
      lv = s2_q ^ pol;
      coast_d = csx_fn_any(fa, lv, `CSX_FN_COAST);
      trip_d = csx_fn_any(fa, lv, `CSX_FN_TRIP);
      rise_d = trip_d & ~trip_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 8'h00;
         s2_q <= 8'h00;
         coast_q <= 1'b0;
         trip_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         coast_q <= coast_d;
         trip_q <= trip_d;
         rise_q <= rise_d;
      end
   end

   assign tio.coast = coast_q;
   assign tio.trip_lvl = trip_q;
   assign tio.trip_rise = rise_q;

   AST_RISE_LVL: assert property (@(posedge clk) disable iff (!rst_n)
      rise_q |-> trip_q && !$past(trip_q)) else $error("trip edge without level");
endmodule

// [hw/csx_axil.sv]
`timescale 1ns/1ps
`include "csx_regs.svh"
module csx_axil (
   input wire logic clk, // Clock
   input wire logic rst_n, // Async reset, low
   input wire logic [7:0] awaddr, // Write address
   input wire logic awvalid, // Write address valid
   output logic awready, // Write address ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb, // Byte enables
   input wire logic wvalid, // Write data valid
   output logic wready, // Write data ready
   output csx_pkg::csx_resp_t bresp, // Write response
   output logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   input wire logic [7:0] araddr, // Read address
   input wire logic arvalid, // Read address valid
   output logic arready, // Read address ready
   output logic [31:0] rdata, // Read data
   output csx_pkg::csx_resp_t rresp, // Read response
   output logic rvalid, // Read data valid
   input wire logic rready, // Read data ready
   csx_cfg_if.regs cfg // Settings and status
);
   import csx_pkg::*;
   logic awr_q, awr_d, wr_q, wr_d, awh_q, awh_d, wh_q, wh_d, bv_q, bv_d;
   logic arr_q, arr_d, rv_q, rv_d, krst_q, krst_d, wr_en;
   logic [7:0] aa_q, aa_d, wa;
   logic [31:0] wd_q, wd_d, wd, rd_q, rd_d, ctrl;
   logic [3:0] ws_q, ws_d, ws;
   csx_resp_t br_q, br_d, rr_q, rr_d;
   logic [31:0] ctrl_q, ctrl_d, pol_q, pol_d, flo_q, flo_d, fhi_q, fhi_d, dly_q, dly_d;

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[8*b +: 8] = n[8*b +: 8];
         end
      end
      return r;
   endfunction

   always_comb begin
      awh_d = awh_q | (awvalid & awr_q);
      aa_d = (awvalid & awr_q) ? awaddr : aa_q;
      wh_d = wh_q | (wvalid & wr_q);
      wd_d = (wvalid & wr_q) ? wdata : wd_q;
      ws_d = (wvalid & wr_q) ? wstrb : ws_q;
      wa = aa_d;
      wd = wd_d;
      ws = ws_d;
      bv_d = bv_q & ~bready;
      br_d = br_q;
      wr_en = awh_d & wh_d & ~bv_q;
      ctrl_d = ctrl_q;
      pol_d = pol_q;
      flo_d = flo_q;
      fhi_d = fhi_q;
      dly_d = dly_q;
      krst_d = 1'b0;
      ctrl = ctrl_q;
      if (wr_en) begin
         awh_d = 1'b0;
         wh_d = 1'b0;
         bv_d = 1'b1;
         br_d = CSX_OKAY;
         unique case (wa)
            `CSX_OFS_CTRL: begin
               ctrl = merge(ctrl_q, wd, ws);
               ctrl_d = {30'h0, ctrl[`CSX_CTRL_GUARD], ctrl[`CSX_CTRL_MODE]};
               krst_d = ws[0] & wd[`CSX_CTRL_KRST];
            end
            `CSX_OFS_POL: pol_d = merge(pol_q, wd, ws) & 32'h0000_00ff;
            `CSX_OFS_FLO: flo_d = merge(flo_q, wd, ws);
            `CSX_OFS_FHI: fhi_d = merge(fhi_q, wd, ws);
            `CSX_OFS_DLY: dly_d = merge(dly_q, wd, ws) & 32'h0000_ffff;
            `CSX_OFS_STAT: br_d = CSX_OKAY;
            default: br_d = CSX_SLVERR;
         endcase
      end
      awr_d = ~awh_d & ~bv_d;
      wr_d = ~wh_d & ~bv_d;
      rv_d = rv_q & ~rready;
      rd_d = rd_q;
      rr_d = rr_q;
      arr_d = arr_q | (rv_q & rready);
      if (arvalid & arr_q) begin
         arr_d = 1'b0;
         rv_d = 1'b1;
         rr_d = CSX_OKAY;
         unique case (araddr)
            `CSX_OFS_CTRL: rd_d = ctrl_q;
            `CSX_OFS_POL: rd_d = pol_q;
            `CSX_OFS_FLO: rd_d = flo_q;
            `CSX_OFS_FHI: rd_d = fhi_q;
            `CSX_OFS_DLY: rd_d = dly_q;
            `CSX_OFS_STAT: rd_d = cfg.stat;
            default: begin
               rd_d = 32'h0000_0000;
               rr_d = CSX_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {awr_q, wr_q, arr_q} <= 3'h7;
         {awh_q, wh_q, bv_q, rv_q, krst_q} <= 5'h00;
         aa_q <= 8'h00;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         br_q <= CSX_OKAY;
         rr_q <= CSX_OKAY;
         rd_q <= 32'h0000_0000;
         ctrl_q <= `CSX_RST_CTRL;
         pol_q <= `CSX_RST_POL;
         flo_q <= `CSX_RST_FUNC;
         fhi_q <= `CSX_RST_FUNC;
         dly_q <= `CSX_RST_DLY;
      end else begin
         {awr_q, wr_q, arr_q} <= {awr_d, wr_d, arr_d};
         {awh_q, wh_q, bv_q, rv_q, krst_q} <= {awh_d, wh_d, bv_d, rv_d, krst_d};
         aa_q <= aa_d;
         wd_q <= wd_d;
         ws_q <= ws_d;
         br_q <= br_d;
         rr_q <= rr_d;
         rd_q <= rd_d;
         ctrl_q <= ctrl_d;
         pol_q <= pol_d;
         flo_q <= flo_d;
         fhi_q <= fhi_d;
         dly_q <= dly_d;
      end
   end

   assign {awready, wready, bvalid, bresp} = {awr_q, wr_q, bv_q, br_q};
   assign {arready, rvalid, rdata, rresp} = {arr_q, rv_q, rd_q, rr_q};
   assign cfg.mode = ctrl_q[`CSX_CTRL_MODE];
   assign cfg.guard = ctrl_q[`CSX_CTRL_GUARD];
   assign cfg.krst = krst_q;
   assign cfg.pol = pol_q[7:0];
   assign cfg.fa = {fhi_q, flo_q};
   assign cfg.dly = dly_q[15:0];
endmodule

// [hw/csx_top.sv]
// How it works
// - Coast input active removes drive output
// - Coast released with run restores output
// - Restart from zero or motor speed
// - Wait restart delay; zero means none
// - Coast function is terminal code 11
// - Coast inactive keeps output operating normally
// - Polarity setting inverts a terminal's sense
// - Trip enters trip state, error, coasting
// - Trip latched on rising edge, code 12
// - Falling edge makes no trip; history kept
// - Trip holds until reset
// - Reset clears alarm, error, back to stop
// - Alarm rises together with trip entry
// - Reset release with run resumes drive
// - Guard needs fresh run or reset
`timescale 1ns/1ps
`include "csx_regs.svh"
module csx_top #(
   parameter int unsigned TICK_CYC = `CSX_TICK_CYC
) (
   input wire logic CLK, // 200 MHz clock
   input wire logic RST_N, // Async reset, low
   input wire logic [7:0] S_AXI_AWADDR, // Write address
   input wire logic S_AXI_AWVALID, // Write address valid
   output logic S_AXI_AWREADY, // Write address ready
   input wire logic [31:0] S_AXI_WDATA, // Write data
   input wire logic [3:0] S_AXI_WSTRB, // Byte enables
   input wire logic S_AXI_WVALID, // Write data valid
   output logic S_AXI_WREADY, // Write data ready
   output csx_pkg::csx_resp_t S_AXI_BRESP, // Write response
   output logic S_AXI_BVALID, // Write response valid
   input wire logic S_AXI_BREADY, // Write response ready
   input wire logic [7:0] S_AXI_ARADDR, // Read address
   input wire logic S_AXI_ARVALID, // Read address valid
   output logic S_AXI_ARREADY, // Read address ready
   output logic [31:0] S_AXI_RDATA, // Read data
   output csx_pkg::csx_resp_t S_AXI_RRESP, // Read response
   output logic S_AXI_RVALID, // Read data valid
   input wire logic S_AXI_RREADY, // Read data ready
   input wire logic [7:0] TERM_IN, // Input terminals
   input wire logic RUN_CMD, // Run command level
   input wire logic RESET_TERM_IN, // Reset terminal level
   output logic DRIVE_EN, // Output stage enabled
   output logic RESTART_PULSE, // Resume after coast
   output logic RESTART_FROM_SPEED, // 1: match motor speed
   output logic ALARM, // Alarm output
   output logic [7:0] ERR_CODE // Trip error code
);
   import csx_pkg::*;

   csx_cfg_if cfg();
   csx_term_if tio();

   csx_axil u_axil (
      .clk(CLK),
      .rst_n(RST_N),
      .awaddr(S_AXI_AWADDR),
      .awvalid(S_AXI_AWVALID),
      .awready(S_AXI_AWREADY),
      .wdata(S_AXI_WDATA),
      .wstrb(S_AXI_WSTRB),
      .wvalid(S_AXI_WVALID),
      .wready(S_AXI_WREADY),
      .bresp(S_AXI_BRESP),
      .bvalid(S_AXI_BVALID),
      .bready(S_AXI_BREADY),
      .araddr(S_AXI_ARADDR),
      .arvalid(S_AXI_ARVALID),
      .arready(S_AXI_ARREADY),
      .rdata(S_AXI_RDATA),
      .rresp(S_AXI_RRESP),
      .rvalid(S_AXI_RVALID),
      .rready(S_AXI_RREADY),
      .cfg(cfg.regs)
   );

   csx_insync u_insync (
      .clk(CLK),
      .rst_n(RST_N),
      .term(TERM_IN),
      .pol(cfg.pol),
      .fa(cfg.fa),
      .tio(tio.src)
   );

   csx_state_t st_q, st_d;
   logic [17:0] tk_q, tk_d;
   logic tick;
   logic [15:0] dc_q, dc_d;
   logic rs_q, rs_rise, rst_lvl;
   logic drv_q, drv_d, rp_q, rp_d, rfs_q, rfs_d, al_q, al_d;
   logic [7:0] err_q, err_d, tc_q, tc_d;
   logic [31:0] stat_q, stat_d;

   assign rst_lvl = RESET_TERM_IN | cfg.krst;
   assign rs_rise = RESET_TERM_IN & ~rs_q;

   // Millisecond enable, restarted on every wait entry
   always_comb begin
      tick = (tk_q == 18'(TICK_CYC - 1));
      tk_d = (st_q != ST_WAIT || tick) ? 18'h0 : tk_q + 18'h1;
   end

   always_comb begin
      st_d = st_q;
      rp_d = 1'b0;
      rfs_d = rfs_q;
      dc_d = dc_q;
      tc_d = tc_q;
      if (tio.trip_rise) begin
         st_d = ST_TRIP;
         tc_d = (tc_q == 8'hff) ? tc_q : tc_q + 8'h01;
      end else begin
         unique case (st_q)
            ST_STOP: begin
               if (tio.coast) begin
                  st_d = ST_COAST;
               end else if (RUN_CMD) begin
                  st_d = ST_RUN;
                  rfs_d = 1'b0;
               end
            end
            ST_RUN: begin
               if (tio.coast) begin
                  st_d = ST_COAST;
               end else if (!RUN_CMD) begin
                  st_d = ST_STOP;
               end
            end
            ST_COAST: begin
               if (!tio.coast) begin
                  if (!RUN_CMD) begin
                     st_d = ST_STOP;
                  end else if (cfg.dly == 16'h0) begin
                     st_d = ST_RUN;
                     rp_d = 1'b1;
                     rfs_d = cfg.mode;
                  end else begin
                     st_d = ST_WAIT;
                     dc_d = 16'h0;
                  end
               end
            end
            ST_WAIT: begin
               if (tio.coast) begin
                  st_d = ST_COAST;
               end else if (!RUN_CMD) begin
                  st_d = ST_STOP;
               end else if (tick) begin
                  if (dc_q == cfg.dly - 16'h1) begin
                     st_d = ST_RUN;
                     rp_d = 1'b1;
                     rfs_d = cfg.mode;
                  end else begin
                     dc_d = dc_q + 16'h1;
                  end
               end
            end
            ST_TRIP: begin
               if (rst_lvl) begin
                  st_d = ST_CLR;
               end
            end
            ST_CLR: begin
               tc_d = 8'h00;
               if (!rst_lvl) begin
                  st_d = (cfg.guard && RUN_CMD) ? ST_HOLD : ST_STOP;
               end
            end
            ST_HOLD: begin
               if (!RUN_CMD || cfg.krst || rs_rise) begin
                  st_d = ST_STOP;
               end
            end
            default: begin
               st_d = ST_STOP;
            end
         endcase
      end
   end

   always_comb begin
      drv_d = (st_d == ST_RUN || st_d == ST_STOP) && !tio.coast;
      al_d = (st_d == ST_TRIP);
      err_d = al_d ? `CSX_ERR_EXT : `CSX_ERR_NONE;
      stat_d = {8'h00, tc_d, err_d, 2'h0, tio.coast, al_d, drv_d, st_d};
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q <= ST_STOP;
         tk_q <= 18'h0;
         dc_q <= 16'h0;
         rs_q <= 1'b0;
         drv_q <= 1'b0;
         rp_q <= 1'b0;
         rfs_q <= 1'b0;
         al_q <= 1'b0;
         err_q <= `CSX_ERR_NONE;
         tc_q <= 8'h00;
         stat_q <= 32'h0000_0000;
      end else begin
         st_q <= st_d;
         tk_q <= tk_d;
         dc_q <= dc_d;
         rs_q <= RESET_TERM_IN;
         drv_q <= drv_d;
         rp_q <= rp_d;
         rfs_q <= rfs_d;
         al_q <= al_d;
         err_q <= err_d;
         tc_q <= tc_d;
         stat_q <= stat_d;
      end
   end

   assign DRIVE_EN = drv_q;
   assign RESTART_PULSE = rp_q;
   assign RESTART_FROM_SPEED = rfs_q;
   assign ALARM = al_q;
   assign ERR_CODE = err_q;
   assign cfg.stat = stat_q;

   AST_COAST_OFF: assert property (@(posedge CLK) disable iff (!RST_N)
      tio.coast |=> !DRIVE_EN) else $error("drive on while coasting");

   AST_RESUME: assert property (@(posedge CLK) disable iff (!RST_N)
      st_q == ST_COAST && !tio.coast && RUN_CMD && !tio.trip_rise && cfg.dly == 16'h0
      |=> DRIVE_EN && RESTART_PULSE) else $error("no resume after coast");

   AST_MODE: assert property (@(posedge CLK) disable iff (!RST_N)
      RESTART_PULSE |-> RESTART_FROM_SPEED == $past(cfg.mode)) else $error("bad restart mode");

   AST_WAIT_TICK: assert property (@(posedge CLK) disable iff (!RST_N)
      st_q == ST_WAIT && !tick |=> st_q != ST_RUN) else $error("resume before delay");

   AST_NORMAL: assert property (@(posedge CLK) disable iff (!RST_N)
      st_q == ST_RUN && !tio.coast && !tio.trip_rise |=> DRIVE_EN)
      else $error("drive lost in normal run");

   AST_TRIP_ENTRY: assert property (@(posedge CLK) disable iff (!RST_N)
      tio.trip_rise |=> st_q == ST_TRIP && !DRIVE_EN) else $error("trip edge missed");

   AST_ERR: assert property (@(posedge CLK) disable iff (!RST_N)
      ALARM |-> ERR_CODE == `CSX_ERR_EXT && !DRIVE_EN) else $error("trip error wrong");

   AST_NO_FALL: assert property (@(posedge CLK) disable iff (!RST_N)
      st_q != ST_TRIP && !tio.trip_rise |=> st_q != ST_TRIP) else $error("trip without edge");

   AST_HOLD_TRIP: assert property (@(posedge CLK) disable iff (!RST_N)
      st_q == ST_TRIP && !rst_lvl |=> st_q == ST_TRIP && ALARM) else $error("trip dropped");

   AST_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N)
      st_q == ST_TRIP && rst_lvl && !tio.trip_rise |=> !ALARM && ERR_CODE == `CSX_ERR_NONE)
      else $error("reset did not clear");

   AST_ALARM_NOW: assert property (@(posedge CLK) disable iff (!RST_N)
      ALARM == (st_q == ST_TRIP)) else $error("alarm not with trip");

   AST_RELEASE: assert property (@(posedge CLK) disable iff (!RST_N)
      st_q == ST_CLR && !rst_lvl && !cfg.guard && RUN_CMD && !tio.trip_rise && !tio.coast
      |=> DRIVE_EN) else $error("no resume on reset release");

   AST_GUARD: assert property (@(posedge CLK) disable iff (!RST_N)
      st_q == ST_HOLD && RUN_CMD && !cfg.krst && !rs_rise && !tio.trip_rise
      |=> !DRIVE_EN) else $error("guard restarted drive");

   AST_KEYPAD_CLR: assert property (@(posedge CLK) disable iff (!RST_N)
      st_q == ST_TRIP && cfg.krst && !tio.trip_rise |=> st_q == ST_CLR && !ALARM)
      else $error("keypad reset did not clear");

   AST_GUARD_ENTRY: assert property (@(posedge CLK) disable iff (!RST_N)
      st_q == ST_CLR && !rst_lvl && cfg.guard && RUN_CMD && !tio.trip_rise
      |=> st_q == ST_HOLD && !DRIVE_EN) else $error("guard did not hold");

   AST_ERR_IDLE: assert property (@(posedge CLK) disable iff (!RST_N)
      !ALARM |-> ERR_CODE == `CSX_ERR_NONE) else $error("error code without trip");

   AST_PULSE_ONE: assert property (@(posedge CLK) disable iff (!RST_N)
      RESTART_PULSE |=> !RESTART_PULSE) else $error("restart pulse too long");
endmodule

// [test/csx_partner.sv]
`timescale 1ns/1ps
module csx_partner (
   input wire logic clk, // Clock
   output logic [7:0] term, // Contact levels
   output logic run, // Run command
   output logic rst // Reset terminal
);
   initial begin
      term = 8'h00;
      run = 1'b0;
      rst = 1'b0;
   end
   task automatic set_term(input int i, input logic v);
      @(posedge clk);
      term[i] <= v;
   endtask
   task automatic set_run(input logic v);
      @(posedge clk);
      run <= v;
   endtask
   task automatic set_rst(input logic v);
      @(posedge clk);
      rst <= v;
   endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
`include "csx_regs.svh"
module tb_top;
   import csx_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready;
   logic wready;
   logic bvalid;
   logic arready;
   logic rvalid;
   csx_resp_t bresp;
   csx_resp_t rresp;
   logic [31:0] rdata;
   logic [7:0] term;
   logic run;
   logic rste;
   logic drive;
   logic rpulse;
   logic rspeed;
   logic alarm;
   logic [7:0] err;
   int err_count = 0;
   int tests_run = 0;

   always #2.5 clk = ~clk;

   csx_partner csx_partner_inst (.clk(clk), .term(term), .run(run), .rst(rste));
   csx_top #(.TICK_CYC(4)) csx_top_inst (
      .CLK(clk), .RST_N(rst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .TERM_IN(term),
      .RUN_CMD(run), .RESET_TERM_IN(rste), .DRIVE_EN(drive),
      .RESTART_PULSE(rpulse), .RESTART_FROM_SPEED(rspeed), .ALARM(alarm),
      .ERR_CODE(err)
   );

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic hang(input string nm);
      err_count++;
      $display("[FAIL] %s exp done got timeout", nm);
      print_verdict();
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input csx_resp_t er);
      logic ta;
      logic tw;
      logic tb;
      tb = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 40 && !tb; n++) begin
         @(negedge clk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = (bvalid === 1'b1);
         if (tb) chk("bresp", er, bresp);
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
      end
      if (!tb) hang("write");
   endtask
   task automatic rd(input logic [7:0] a, input csx_resp_t er, output logic [31:0] d);
      logic ta;
      logic tr;
      tr = 1'b0;
      d = 32'h0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 40 && !tr; n++) begin
         @(negedge clk);
         ta = arvalid & arready;
         tr = (rvalid === 1'b1);
         if (tr) begin
            d = rdata;
            chk("rresp", er, rresp);
         end
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
      end
      if (!tr) hang("read");
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic wait_restart(output int n);
      logic seen;
      seen = 1'b0;
      n = 0;
      while (!seen && n < 200) begin
         @(negedge clk);
         n++;
         seen = (rpulse === 1'b1);
      end
      if (!seen) hang("restart");
   endtask

   task automatic t_reset();
      logic [31:0] d;
      chk("drive idle", 1'b1, drive);
      chk("alarm idle", 1'b0, alarm);
      chk("err idle", `CSX_ERR_NONE, err);
      rd(`CSX_OFS_CTRL, CSX_OKAY, d);
      chk("ctrl rst", `CSX_RST_CTRL, d);
      rd(8'h20, CSX_SLVERR, d);
      chk("unmapped", 32'h0, d);
      wr(8'h20, 32'hffff_ffff, CSX_SLVERR);
      // Coast on terminal 2, coast on 5, trip on 6
      wr(`CSX_OFS_FLO, 32'h000b_0000, CSX_OKAY);
      wr(`CSX_OFS_FHI, 32'h000c_0b00, CSX_OKAY);
      // Only byte 2 enabled; other lanes keep their value
      wstrb <= 4'h4;
      wr(`CSX_OFS_FLO, 32'hee0b_eeee, CSX_OKAY);
      wstrb <= 4'hf;
      rd(`CSX_OFS_FLO, CSX_OKAY, d);
      chk("func lo", 32'h000b_0000, d);
      $display("test reset done");
   endtask
   task automatic t_coast();
      int n;
      csx_partner_inst.set_run(1'b1);
      for (int m = 0; m < 2; m++) begin
         wr(`CSX_OFS_CTRL, m, CSX_OKAY);
         csx_partner_inst.set_term(2, 1'b1);
         wait_cyc(5);
         chk("coast drive", 1'b0, drive);
         csx_partner_inst.set_term(2, 1'b0);
         wait_restart(n);
         chk("resume drive", 1'b1, drive);
         chk("restart mode", m, rspeed);
         chk("no delay", 1'b1, n <= 6);
      end
      $display("test coast done");
   endtask
   task automatic t_delay();
      int n;
      wr(`CSX_OFS_DLY, 32'h2, CSX_OKAY);
      csx_partner_inst.set_term(2, 1'b1);
      wait_cyc(5);
      csx_partner_inst.set_term(2, 1'b0);
      wait_restart(n);
      chk("delay min", 1'b1, n >= 8);
      chk("delay max", 1'b1, n <= 16);
      wr(`CSX_OFS_DLY, 32'h0, CSX_OKAY);
      $display("test delay done");
   endtask
   task automatic t_pol();
      int n;
      wr(`CSX_OFS_POL, 32'h20, CSX_OKAY);
      wait_cyc(5);
      chk("inv low", 1'b0, drive);
      csx_partner_inst.set_term(5, 1'b1);
      wait_restart(n);
      chk("inv high", 1'b1, drive);
      csx_partner_inst.set_term(5, 1'b0);
      wait_cyc(5);
      wr(`CSX_OFS_POL, 32'h0, CSX_OKAY);
      wait_restart(n);
      chk("pol off", 1'b1, drive);
      $display("test polarity done");
   endtask
   task automatic t_trip();
      logic [31:0] d;
      csx_partner_inst.set_term(6, 1'b1);
      wait_cyc(4);
      chk("alarm at trip", 1'b1, alarm);
      chk("trip err", `CSX_ERR_EXT, err);
      chk("trip drive", 1'b0, drive);
      csx_partner_inst.set_term(6, 1'b0);
      wait_cyc(6);
      chk("trip held", 1'b1, alarm);
      rd(`CSX_OFS_STAT, CSX_OKAY, d);
      chk("trip state", 32'h4, d[2:0]);
      chk("trip count", 32'h1, d[23:16]);
      csx_partner_inst.set_rst(1'b1);
      wait_cyc(3);
      chk("alarm clr", 1'b0, alarm);
      chk("err clr", `CSX_ERR_NONE, err);
      csx_partner_inst.set_rst(1'b0);
      wait_cyc(3);
      chk("resume run", 1'b1, drive);
      chk("plain start", 1'b0, rspeed);
      $display("test trip done");
   endtask
   task automatic t_guard();
      logic [31:0] d;
      wr(`CSX_OFS_CTRL, 32'h2, CSX_OKAY);
      csx_partner_inst.set_term(6, 1'b1);
      wait_cyc(4);
      chk("guard trip", 1'b1, alarm);
      csx_partner_inst.set_term(6, 1'b0);
      csx_partner_inst.set_rst(1'b1);
      wait_cyc(3);
      csx_partner_inst.set_rst(1'b0);
      wait_cyc(4);
      chk("guard hold", 1'b0, drive);
      csx_partner_inst.set_run(1'b0);
      wait_cyc(4);
      chk("guard left", 1'b1, drive);
      rd(`CSX_OFS_STAT, CSX_OKAY, d);
      chk("trip count clr", 32'h0, d[23:16]);
      csx_partner_inst.set_run(1'b1);
      csx_partner_inst.set_term(6, 1'b1);
      wait_cyc(4);
      chk("kp trip", 1'b1, alarm);
      csx_partner_inst.set_term(6, 1'b0);
      // Keypad reset with guard kept on
      wr(`CSX_OFS_CTRL, 32'h6, CSX_OKAY);
      wait_cyc(3);
      chk("kp clr", 1'b0, alarm);
      chk("kp hold", 1'b0, drive);
      wr(`CSX_OFS_CTRL, 32'h6, CSX_OKAY);
      wait_cyc(3);
      chk("kp left", 1'b1, drive);
      rd(`CSX_OFS_CTRL, CSX_OKAY, d);
      chk("ctrl no krst", 32'h2, d);
      $display("test guard done");
   endtask

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      wait_cyc(2);
      t_reset();
      t_coast();
      t_delay();
      t_pol();
      t_trip();
      t_guard();
      print_verdict();
   end
endmodule
